// ==== pkg/fif_pkg.sv ====
// package for the fifo interrupt flag and flush block: sfr addresses,
// field positions, reset values and the packed carrier types.
// assumes an 8-bit sfr bus with byte addresses as printed.
package fif_pkg;

    // sfr addresses
    localparam logic [7:0] FIF_FLAGS_ADDR = 8'h9F;
    localparam logic [7:0] FIF_EN_ADDR = 8'hA1;

    // flag register fields
    localparam int FIF_NUM_FLAGS = 6;
    localparam int FIF_CLR_MODE_BIT = 7;
    localparam int FIF_WCOL_BIT = 5;
    localparam int FIF_TXLOW_BIT = 4;
    localparam int FIF_TXFULL_BIT = 3;
    localparam int FIF_RXHIGH_BIT = 2;
    localparam int FIF_RXOVR_BIT = 1;
    localparam int FIF_RXFULL_BIT = 0;

    // enable and flush register fields
    localparam int FIF_TX_FLUSH_BIT = 7;
    localparam int FIF_RX_FLUSH_BIT = 6;

    // reset values
    localparam logic [5:0] FIF_FLAGS_RST = 6'h00;
    localparam logic [5:0] FIF_EN_RST = 6'h00;
    localparam logic [7:0] FIF_RDATA_RST = 8'h00;

    // sfr bus request from the cpu
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } fif_sfr_req_type;

    // fifo manager events and levels
    typedef struct packed {
        logic data_wr;
        logic rx_byte_done;
        logic tx_full;
        logic rx_full;
    } fif_fifo_evt_type;

    // whole state of the block
    typedef struct packed {
        logic [5:0] flags;
        logic [5:0] en;
        logic [7:0] rdata;
        logic irq;
        logic tx_flush;
        logic rx_flush;
        logic rx_store;
    } fif_state_type;

endpackage

// ==== logic/fif_irq_flush.sv ====
// fifo interrupt flags, per-flag enables, combined interrupt and the
// transmit/receive pointer flush strobes, reached over the cpu sfr bus.
// assumes all inputs synchronous to sys_clk; fifo storage, counters and
// threshold registers live outside and feed counts and thresholds in.
`timescale 1ns/1ps

// Notes on behaviour
// - interrupt is OR of six flags, each gated by its enable bit
// - flag write with bit 7 high clears flags written as one
// - data write while transmit fifo full sets write collision flag
// - transmit count at or below transmit threshold sets low-level flag
// - transmit fifo full sets transmit-full flag
// - receive count at or above receive threshold sets high-level flag
// - byte arriving on full receive fifo is dropped, overrun flag set
// - receive fifo full sets receive-full flag
// - enable write with bit 7 high flushes transmit pointer
// - enable write with bit 6 high flushes receive pointer
// - enable bits 5..3 gate collision, transmit low and full flags
// - enable bits 2..0 gate receive high, overrun and full flags
// - thresholds are separate CNT_W-bit values held outside this block
module fif_irq_flush import fif_pkg::*; #(
    parameter int CNT_W = 8
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire fif_sfr_req_type sfr_req,
    input wire fif_fifo_evt_type fifo_evt,
    input wire logic [CNT_W-1:0] tx_count,
    input wire logic [CNT_W-1:0] rx_count,
    input wire logic [CNT_W-1:0] tx_threshold,
    input wire logic [CNT_W-1:0] rx_threshold,
    output logic [7:0] sfr_rdata,
    output logic fifo_irq,
    output logic tx_pointer_flush,
    output logic rx_pointer_flush,
    output logic rx_store
);

    // counts wider than the byte path cannot be served
    if (CNT_W < 1 || CNT_W > 8) begin : g_cnt_check
        $error("fif_irq_flush: CNT_W must be 1 to 8");
    end

    fif_state_type st_r;
    fif_state_type st_nxt;
    logic [5:0] set_evt;
    logic wr_flags;
    logic wr_en;
    logic tx_flush_req;
    logic rx_flush_req;
    logic [5:0] wr_field;

    // decode of sfr writes
    assign wr_flags = sfr_req.wr && (sfr_req.addr == FIF_FLAGS_ADDR);
    assign wr_en = sfr_req.wr && (sfr_req.addr == FIF_EN_ADDR);

    // flush requests and the written low field, named so the checks
    // below can look back at them one cycle later
    assign tx_flush_req = wr_en && sfr_req.wdata[FIF_TX_FLUSH_BIT];
    assign rx_flush_req = wr_en && sfr_req.wdata[FIF_RX_FLUSH_BIT];
    assign wr_field = sfr_req.wdata[5:0];

    // hardware set conditions, one per flag
    always_comb begin
        set_evt = 6'h00;
        set_evt[FIF_WCOL_BIT] = fifo_evt.data_wr && fifo_evt.tx_full;
        set_evt[FIF_TXLOW_BIT] = (tx_count <= tx_threshold);
        set_evt[FIF_TXFULL_BIT] = fifo_evt.tx_full;
        set_evt[FIF_RXHIGH_BIT] = (rx_count >= rx_threshold);
        set_evt[FIF_RXOVR_BIT] = fifo_evt.rx_byte_done
            && fifo_evt.rx_full;
        set_evt[FIF_RXFULL_BIT] = fifo_evt.rx_full;
    end

    // next state; strobes are one-cycle pulses, everything else holds
    always_comb begin
        st_nxt = st_r;
        st_nxt.tx_flush = 1'b0;
        st_nxt.rx_flush = 1'b0;
        // a dropped byte is simply never strobed into storage
        st_nxt.rx_store = fifo_evt.rx_byte_done
            && !fifo_evt.rx_full;
        // software side first, so a same-cycle hardware set wins below
        if (wr_flags) begin
            if (sfr_req.wdata[FIF_CLR_MODE_BIT]) begin
                st_nxt.flags = st_r.flags & ~sfr_req.wdata[5:0];
            end else begin
                st_nxt.flags = st_r.flags | sfr_req.wdata[5:0];
            end
        end
        st_nxt.flags = st_nxt.flags | set_evt;
        if (wr_en) begin
            // a flush write only flushes, enables stay as they were
            if (sfr_req.wdata[FIF_TX_FLUSH_BIT]
                    || sfr_req.wdata[FIF_RX_FLUSH_BIT]) begin
                st_nxt.tx_flush = sfr_req.wdata[FIF_TX_FLUSH_BIT];
                st_nxt.rx_flush = sfr_req.wdata[FIF_RX_FLUSH_BIT];
            end else begin
                st_nxt.en = sfr_req.wdata[5:0];
            end
        end
        st_nxt.irq = |(st_nxt.flags & st_nxt.en);
        // read data; reserved bit 6 and flush bits read zero
        if (sfr_req.rd && sfr_req.addr == FIF_FLAGS_ADDR) begin
            st_nxt.rdata = {2'b00, st_r.flags};
        end else if (sfr_req.rd && sfr_req.addr == FIF_EN_ADDR) begin
            st_nxt.rdata = {2'b00, st_r.en};
        end else if (sfr_req.rd) begin
            st_nxt.rdata = FIF_RDATA_RST;
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_r.flags <= FIF_FLAGS_RST;
            st_r.en <= FIF_EN_RST;
            st_r.rdata <= FIF_RDATA_RST;
            st_r.irq <= 1'b0;
            st_r.tx_flush <= 1'b0;
            st_r.rx_flush <= 1'b0;
            st_r.rx_store <= 1'b0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign sfr_rdata = st_r.rdata;
    assign fifo_irq = st_r.irq;
    assign tx_pointer_flush = st_r.tx_flush;
    assign rx_pointer_flush = st_r.rx_flush;
    assign rx_store = st_r.rx_store;

    // checks: each looks one cycle after its cause, since every output
    // and flag is registered
    AST_IRQ_OR: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        clk_en |=> fifo_irq == |(st_r.flags & st_r.en))
        else $error("interrupt does not match enabled flags");

    AST_W1C_RXFULL: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && wr_flags && sfr_req.wdata[FIF_CLR_MODE_BIT]
        && sfr_req.wdata[FIF_RXFULL_BIT] && !fifo_evt.rx_full
        |=> !st_r.flags[FIF_RXFULL_BIT])
        else $error("write-one clear did not clear flag");

    AST_WCOL: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && fifo_evt.data_wr && fifo_evt.tx_full
        |=> st_r.flags[FIF_WCOL_BIT])
        else $error("write collision flag not set");

    AST_TXLOW: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && tx_count <= tx_threshold
        |=> st_r.flags[FIF_TXLOW_BIT])
        else $error("transmit low flag not set");

    AST_TXFULL: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && fifo_evt.tx_full |=> st_r.flags[FIF_TXFULL_BIT])
        else $error("transmit full flag not set");

    AST_RXHIGH: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && rx_count >= rx_threshold
        |=> st_r.flags[FIF_RXHIGH_BIT])
        else $error("receive high flag not set");

    AST_OVERRUN: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && fifo_evt.rx_byte_done && fifo_evt.rx_full
        |=> st_r.flags[FIF_RXOVR_BIT] && !rx_store)
        else $error("overrun byte stored or flag not set");

    AST_RX_STORE: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && fifo_evt.rx_byte_done && !fifo_evt.rx_full |=> rx_store)
        else $error("received byte not stored");

    AST_RXFULL: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && fifo_evt.rx_full |=> st_r.flags[FIF_RXFULL_BIT])
        else $error("receive full flag not set");

    // back-to-back flush writes may hold a strobe high, so the end of a
    // pulse is only demanded when no new request follows
    AST_TX_POINTER_FLUSH: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && tx_flush_req |=> tx_pointer_flush)
        else $error("transmit flush pulse missing");

    AST_TX_POINTER_FLUSH_END: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && tx_pointer_flush && !tx_flush_req |=> !tx_pointer_flush)
        else $error("transmit flush pulse too long");

    AST_RX_POINTER_FLUSH: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && rx_flush_req |=> rx_pointer_flush)
        else $error("receive flush pulse missing");

    AST_RX_POINTER_FLUSH_END: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && rx_pointer_flush && !rx_flush_req |=> !rx_pointer_flush)
        else $error("receive flush pulse too long");

    AST_EN_WRITE: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && wr_en && !tx_flush_req && !rx_flush_req
        |=> st_r.en == $past(wr_field))
        else $error("enable write not stored");

    AST_FLUSH_KEEPS_EN: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        tx_flush_req || rx_flush_req
        |=> st_r.en == $past(st_r.en))
        else $error("flush write changed enables");

    AST_STICKY: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !(clk_en && wr_flags && sfr_req.wdata[FIF_CLR_MODE_BIT])
        |=> (st_r.flags & $past(st_r.flags)) == $past(st_r.flags))
        else $error("flag dropped without a clear write");

    AST_SET_MODE: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && wr_flags && !sfr_req.wdata[FIF_CLR_MODE_BIT]
        |=> (st_r.flags & $past(wr_field)) == $past(wr_field))
        else $error("set-mode write did not set flags");

    AST_RDATA_FLAGS: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && sfr_req.rd && sfr_req.addr == FIF_FLAGS_ADDR
        |=> sfr_rdata == {2'b00, $past(st_r.flags)})
        else $error("flag read data wrong");

    // a low clock enable must leave every bit of state alone
    AST_FREEZE: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !clk_en |=> st_r == $past(st_r))
        else $error("state changed while clock enable low");

endmodule

// ==== tb/fif_fifo_model.sv ====
// partner model: transmit and receive fifo counters of the fifo manager.
// assumes one-cycle flush and store pulses from the block on sys_clk.
`timescale 1ns/1ps
module fif_fifo_model import fif_pkg::*; #(
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic tx_push,
    input wire logic tx_pointer_flush,
    input wire logic rx_pointer_flush,
    input wire logic rx_store,
    output logic [7:0] tx_count,
    output logic [7:0] rx_count,
    output logic tx_full,
    output logic rx_full
);
    assign tx_full = (tx_count == 8'(DEPTH));
    assign rx_full = (rx_count >= 8'(DEPTH));
    // rx counts every store, so a store on a full fifo shows up
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_count <= 8'h00;
            rx_count <= 8'h00;
        end else begin
            if (tx_pointer_flush) begin
                tx_count <= 8'h00;
            end else if (tx_push && !tx_full) begin
                tx_count <= tx_count + 8'h01;
            end
            if (rx_pointer_flush) begin
                rx_count <= 8'h00;
            end else if (rx_store) begin
                rx_count <= rx_count + 8'h01;
            end
        end
    end
endmodule

// ==== tb/fif_irq_flush_tb.sv ====
// testbench: drives the sfr bus and fifo events, judges flags and irq.
// assumes a fifo depth of 4, thresholds tx 1 and rx 2.
`timescale 1ns/1ps
module fif_irq_flush_tb import fif_pkg::*;;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic dw = 1'b0;
    logic rb = 1'b0;
    fif_sfr_req_type req = '0;
    fif_fifo_evt_type evt;
    logic [7:0] rdata, tx_cnt, rx_cnt;
    logic irq, txf, rxf, tfl, rfl, rst;
    logic ce = 1'b1;
    logic cpu_fifo_source_enable = 1'b1;
    logic cpu_irq;
    int n_errors = 0;
    int n_tests = 0;
    assign evt = {dw, rb, txf, rxf};
    // cpu interrupt controller gate for this source
    assign cpu_irq = irq && cpu_fifo_source_enable;
    fif_irq_flush #(.CNT_W(8)) dut (.sys_clk(sys_clk), .rstn(rstn),
        .clk_en(ce), .sfr_req(req), .fifo_evt(evt), .tx_count(tx_cnt),
        .rx_count(rx_cnt), .tx_threshold(8'h01), .rx_threshold(8'h02),
        .sfr_rdata(rdata), .fifo_irq(irq), .tx_pointer_flush(tfl),
        .rx_pointer_flush(rfl), .rx_store(rst));
    fif_fifo_model #(.DEPTH(4)) fifo (.sys_clk(sys_clk), .rstn(rstn),
        .tx_push(dw), .tx_pointer_flush(tfl), .rx_pointer_flush(rfl),
        .rx_store(rst), .tx_count(tx_cnt), .rx_count(rx_cnt),
        .tx_full(txf), .rx_full(rxf));
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(input string n, input logic [7:0] s, e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge sys_clk) req = '{addr:a, wr:1'b1, rd:1'b0, wdata:d};
        @(negedge sys_clk) req = '0;
    endtask
    // read answer lands at the read edge, so look at the next negedge
    task automatic rchk(input string n, input logic [7:0] a, e);
        @(negedge sys_clk) req = '{addr:a, wr:1'b0, rd:1'b1, wdata:8'h00};
        @(negedge sys_clk) req = '0;
        chk(n, rdata, e);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(negedge sys_clk);
        chk("irq", {7'h00, irq}, {7'h00, e});
        chk("cpu_irq", {7'h00, cpu_irq}, {7'h00, e});
    endtask
    task automatic ev(input bit tx, input int k);
        repeat (k) begin
            @(negedge sys_clk) if (tx) dw = 1'b1; else rb = 1'b1;
            @(negedge sys_clk) begin dw = 1'b0; rb = 1'b0; end
        end
    endtask
    task automatic t_regs;
        rchk("en", FIF_EN_ADDR, 8'h00);
        rchk("flags", FIF_FLAGS_ADDR, 8'h10);
        wr(FIF_FLAGS_ADDR, 8'h4A);
        rchk("set", FIF_FLAGS_ADDR, 8'h1A);
        wr(FIF_FLAGS_ADDR, 8'hBF);
        rchk("clr", FIF_FLAGS_ADDR, 8'h10);
    endtask
    task automatic t_mask;
        for (int i = 0; i < 6; i++) begin
            wr(FIF_FLAGS_ADDR, 8'h01 << i);
            wr(FIF_EN_ADDR, 8'h01 << i);
            irq_is(1'b1);
            wr(FIF_FLAGS_ADDR, 8'h80 | (8'h01 << i));
            irq_is(i == 4);
        end
        // low-level flag stays set, so the source gate alone must mask it
        wr(FIF_EN_ADDR, 8'h10);
        @(negedge sys_clk) cpu_fifo_source_enable = 1'b0;
        @(negedge sys_clk) chk("cpu_gate", {7'h00, cpu_irq}, 8'h00);
        cpu_fifo_source_enable = 1'b1;
        wr(FIF_EN_ADDR, 8'h00);
        irq_is(1'b0);
    endtask
    task automatic t_tx;
        ev(1, 4);
        rchk("txfull", FIF_FLAGS_ADDR, 8'h18);
        ev(1, 1);
        rchk("wcol", FIF_FLAGS_ADDR, 8'h38);
        wr(FIF_FLAGS_ADDR, 8'hB8);
        rchk("reset", FIF_FLAGS_ADDR, 8'h08);
        wr(FIF_EN_ADDR, 8'h15);
        wr(FIF_EN_ADDR, 8'h80);
        @(negedge sys_clk) chk("txcnt", tx_cnt, 8'h00);
        rchk("keep", FIF_EN_ADDR, 8'h15);
    endtask
    task automatic t_rx;
        wr(FIF_FLAGS_ADDR, 8'hBF);
        ev(0, 4);
        // full shows one cycle after the model counts the last store
        @(negedge sys_clk);
        rchk("rxhi", FIF_FLAGS_ADDR, 8'h15);
        ev(0, 1);
        rchk("ovr", FIF_FLAGS_ADDR, 8'h17);
        chk("rxcnt", rx_cnt, 8'h04);
        wr(FIF_EN_ADDR, 8'h40);
        @(negedge sys_clk) chk("rxflush", rx_cnt, 8'h00);
    endtask
    // a clear write with clock enable low is ignored; a mid-run reset
    // returns enables to zero and flags to only the transmit low flag (8'h10)
    task automatic t_hold;
        @(negedge sys_clk) ce = 1'b0;
        wr(FIF_FLAGS_ADDR, 8'hBF);
        ce = 1'b1;
        rchk("frozen", FIF_FLAGS_ADDR, 8'h17);
        rstn = 1'b0;
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        rchk("rst_en", FIF_EN_ADDR, 8'h00);
        rchk("rst_flags", FIF_FLAGS_ADDR, 8'h10);
    endtask
    task automatic report_and_stop;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge sys_clk);
        rstn = 1'b1;
        t_regs();
        t_mask();
        t_tx();
        t_rx();
        t_hold();
        report_and_stop();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        report_and_stop();
    end
endmodule
